// ===== common/nibble_alu_pkg.sv
// constants shared by the nibble arithmetic datapath
package nibble_alu_pkg;
   // datapath widths
   localparam int NIB_W      = 4;     // one data nibble
   localparam int OPC_W      = 8;     // one instruction byte
   localparam int RAM_ADDR_W = 7;     // direct ram operand address
   localparam int WREG_SEL_W = 4;     // working register selector

   // instruction group codes held in the upper nibble of the first byte
   localparam logic [3:0] GRP_CARRY_IN   = 4'h0;  // sums and differences using carry_flag
   localparam logic [3:0] GRP_PLAIN      = 4'h1;  // sums and differences without carry in
   localparam logic [3:0] GRP_KEEP_CARRY = 4'h2;  // sums that leave carry_flag alone

   // field positions inside the lower nibble of the first byte
   localparam int OPC_STORE_BIT = 0;  // 1: write result back to the operand
   localparam int OPC_SUB_BIT   = 1;  // 1: subtract instead of add
   localparam int OPC_IMM_BIT   = 2;  // 1: working register and immediate operands
   localparam int OPC_ARITH_BIT = 3;  // always 1 within the arithmetic group

   // step opcode; bit 7 of the second byte picks the direction
   localparam logic [7:0] OPC_STEP     = 8'h4a;
   localparam int         STEP_DIR_BIT = 7;   // 0: step up, 1: step_down_one

   // fields of the second byte
   localparam int RAM_FORM_BIT = 7;   // must be 0 for ram operand forms
   localparam int IMM_LSB      = 4;   // immediate sits in the upper nibble
   localparam int WREG_LSB     = 0;   // working register number in lower nibble

   // values after reset, and the step increment
   localparam logic [3:0] RESULT_RESET = 4'h0;
   localparam logic       CARRY_RESET  = 1'b0;
   localparam logic       ZERO_RESET   = 1'b1;
   localparam logic [3:0] STEP_ONE     = 4'h1;
endpackage

// ===== design/nibble_adder.sv
// four bit adder and subtractor with carry or borrow in and out
`timescale 1ns/1ns
module nibble_adder #(
   parameter int W = 4                    // operand width
) (
   input  wire logic [W-1:0] op_a,        // minuend or first addend
   input  wire logic [W-1:0] op_b,        // subtrahend or second addend
   input  wire logic         cin,         // carry in, or borrow in when subtracting
   input  wire logic         sub,         // 1: op_a - op_b - cin
   output logic      [W-1:0] sum,         // result nibble
   output logic              cout         // carry out, or borrow out when subtracting
);
   logic [W:0] wide;                      // result with carry position

   // subtraction is done as a + ~b + ~borrow; the borrow is the missing carry
   always_comb begin
      if (sub) begin
         wide = {1'b0, op_a} + {1'b0, ~op_b} + {{W{1'b0}}, ~cin};
         cout = ~wide[W];
      end else begin
         wide = {1'b0, op_a} + {1'b0, op_b} + {{W{1'b0}}, cin};
         cout = wide[W];
      end
      sum = wide[W-1:0];
   end
endmodule // nibble_adder

// ===== design/nibble_arithmetic_unit.sv
// arithmetic instruction group of a four bit core: sums, differences, steps
`timescale 1ns/1ns
// Overview of operation
// - ram sum loads result, carry form adds carry
// - immediate sum: working register plus upper immediate
// - ram sum store writes result and ram
// - immediate sum store writes result and register
// - ram difference: ram nibble minus result register
// - immediate difference: working register minus immediate
// - ram difference store writes result and ram
// - immediate difference store, single cycle, both written
module nibble_arithmetic_unit #(
   parameter int NIB_W = nibble_alu_pkg::NIB_W    // data nibble width
) (
   input  wire logic                                  clk_sys,        // core clock
   input  wire logic                                  rst,            // sync reset, active high
   input  wire logic                                  op_valid,       // decoder issues an instruction
   input  wire logic [nibble_alu_pkg::OPC_W-1:0]      op_byte0,       // first instruction byte
   input  wire logic [nibble_alu_pkg::OPC_W-1:0]      op_byte1,       // second instruction byte
   input  wire logic [NIB_W-1:0]                      ram_rd_data,    // ram nibble at op_byte1[6:0]
   input  wire logic [NIB_W-1:0]                      wreg_rd_data,   // working register op_byte1[3:0]
   output logic      [NIB_W-1:0]                      result_nibble_reg, // accumulator
   output logic                                       carry_flag,     // carry or borrow flag
   output logic                                       zero_flag,      // result was zero
   output logic                                       ram_wr_en,      // ram write strobe
   output logic      [nibble_alu_pkg::RAM_ADDR_W-1:0] ram_wr_addr,    // ram write address
   output logic      [NIB_W-1:0]                      ram_wr_data,    // ram write nibble
   output logic                                       wreg_wr_en,     // working register write strobe
   output logic      [nibble_alu_pkg::WREG_SEL_W-1:0] wreg_wr_sel,    // working register number
   output logic      [NIB_W-1:0]                      wreg_wr_data,   // working register nibble
   output logic                                       op_done,        // instruction executed
   output logic                                       op_reject       // opcode not of this group, or malformed ram form
);
   // decoded fields of the issued instruction
   logic [3:0]       grp;              // upper nibble of first byte
   logic             is_arith;         // sum or difference form
   logic             is_step;          // step up or down form
   logic             f_store;          // write the result back
   logic             f_sub;            // subtract
   logic             f_imm;            // immediate operand form
   logic             f_cin;            // take carry_flag in
   logic             f_keep_carry;     // leave carry_flag unchanged
   logic             step_down;        // step direction is down
   logic             ram_form_ok;      // second byte marks a ram operand
   logic             accept;           // instruction belongs here and is well formed
   logic [NIB_W-1:0] imm_nib;          // immediate nibble
   logic [NIB_W-1:0] opnd_a;           // first adder operand
   logic [NIB_W-1:0] opnd_b;           // second adder operand
   logic             adder_cin;        // adder carry or borrow in
   logic             adder_sub;        // adder direction
   logic [NIB_W-1:0] res_d;            // result nibble
   logic             cout_d;           // carry or borrow out

   // state registers
   logic [NIB_W-1:0]                      result_q;     // result register
   logic                                  carry_q;      // carry flag
   logic                                  zero_q;       // zero flag
   logic                                  ram_we_q;     // ram write strobe
   logic [nibble_alu_pkg::RAM_ADDR_W-1:0] ram_addr_q;   // ram address
   logic [NIB_W-1:0]                      ram_data_q;   // ram data
   logic                                  wreg_we_q;    // working register strobe
   logic [nibble_alu_pkg::WREG_SEL_W-1:0] wreg_sel_q;   // working register number
   logic [NIB_W-1:0]                      wreg_data_q;  // working register data
   logic                                  done_q;       // executed pulse
   logic                                  reject_q;     // rejected pulse

   // field split of the two instruction bytes
   always_comb begin
      grp         = op_byte0[7:4];
      f_store     = op_byte0[nibble_alu_pkg::OPC_STORE_BIT];
      f_sub       = op_byte0[nibble_alu_pkg::OPC_SUB_BIT];
      f_imm       = op_byte0[nibble_alu_pkg::OPC_IMM_BIT];
      step_down   = op_byte1[nibble_alu_pkg::STEP_DIR_BIT];
      ram_form_ok = ~op_byte1[nibble_alu_pkg::RAM_FORM_BIT];
      imm_nib     = op_byte1[nibble_alu_pkg::IMM_LSB +: NIB_W];
   end

   // group decode; keep carry group has no difference forms (those are logic ops)
   always_comb begin
      is_step      = (op_byte0 == nibble_alu_pkg::OPC_STEP);
      is_arith     = 1'b0;
      f_cin        = 1'b0;
      f_keep_carry = 1'b0;
      if (op_byte0[nibble_alu_pkg::OPC_ARITH_BIT]) begin
         case (grp)
            nibble_alu_pkg::GRP_CARRY_IN: begin
               is_arith = 1'b1;
               f_cin    = 1'b1;
            end
            nibble_alu_pkg::GRP_PLAIN: begin
               is_arith = 1'b1;
            end
            nibble_alu_pkg::GRP_KEEP_CARRY: begin
               is_arith     = ~f_sub;
               f_keep_carry = 1'b1;
            end
            default: begin
               is_arith = 1'b0;
            end
         endcase
      end
      // ram forms need a zero in the top bit of the second byte
      accept = op_valid & ((is_arith & (f_imm | ram_form_ok)) | (is_step & 1'b1));
   end

   // operand selection for the shared adder
   always_comb begin
      if (is_step) begin
         opnd_a    = ram_rd_data;
         opnd_b    = nibble_alu_pkg::STEP_ONE;
         adder_cin = 1'b0;
         adder_sub = step_down;
      end else if (f_imm) begin
         opnd_a    = wreg_rd_data;
         opnd_b    = imm_nib;
         adder_cin = f_cin & carry_q;
         adder_sub = f_sub;
      end else begin
         opnd_a    = ram_rd_data;
         opnd_b    = result_q;
         adder_cin = f_cin & carry_q;
         adder_sub = f_sub;
      end
   end

   // shared adder and subtractor
   nibble_adder #(
      .W    (NIB_W)
   ) u_adder (
      .op_a (opnd_a),
      .op_b (opnd_b),
      .cin  (adder_cin),
      .sub  (adder_sub),
      .sum  (res_d),
      .cout (cout_d)
   );

   // result register loads every accepted instruction in one cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         result_q <= nibble_alu_pkg::RESULT_RESET;
      end else if (accept) begin
         result_q <= res_d;
      end
   end

   // flags: zero always follows the result, carry unless keep carry form
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         carry_q <= nibble_alu_pkg::CARRY_RESET;
         zero_q  <= nibble_alu_pkg::ZERO_RESET;
      end else if (accept) begin
         zero_q <= (res_d == '0);
         if (!f_keep_carry || is_step) begin
            carry_q <= cout_d;
         end
      end
   end

   // ram write back for ram store forms and steps
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ram_we_q   <= 1'b0;
         ram_addr_q <= '0;
         ram_data_q <= '0;
      end else begin
         ram_we_q <= accept & ~f_imm & (f_store | is_step);
         if (accept) begin
            ram_addr_q <= op_byte1[nibble_alu_pkg::RAM_ADDR_W-1:0];
            ram_data_q <= res_d;
         end
      end
   end

   // working register write back for immediate store forms
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wreg_we_q   <= 1'b0;
         wreg_sel_q  <= '0;
         wreg_data_q <= '0;
      end else begin
         wreg_we_q <= accept & ~is_step & f_imm & f_store;
         if (accept) begin
            wreg_sel_q  <= op_byte1[nibble_alu_pkg::WREG_LSB +: nibble_alu_pkg::WREG_SEL_W];
            wreg_data_q <= res_d;
         end
      end
   end

   // completion and rejection pulses toward the sequencer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         done_q   <= 1'b0;
         reject_q <= 1'b0;
      end else begin
         done_q   <= accept;
         reject_q <= op_valid & ~accept;
      end
   end

   // outputs straight from flip-flops
   assign result_nibble_reg = result_q;
   assign carry_flag        = carry_q;
   assign zero_flag         = zero_q;
   assign ram_wr_en         = ram_we_q;
   assign ram_wr_addr       = ram_addr_q;
   assign ram_wr_data       = ram_data_q;
   assign wreg_wr_en        = wreg_we_q;
   assign wreg_wr_sel       = wreg_sel_q;
   assign wreg_wr_data      = wreg_data_q;
   assign op_done           = done_q;
   assign op_reject         = reject_q;
endmodule // nibble_arithmetic_unit

// ===== tb/nibble_arithmetic_unit_monitor.sv
// port assertions for the nibble arithmetic unit
`timescale 1ns/1ns
module nibble_arithmetic_unit_monitor (
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       op_valid,
   input wire logic [7:0] op_byte0,
   input wire logic [7:0] op_byte1,
   input wire logic [3:0] ram_rd_data,
   input wire logic [3:0] wreg_rd_data,
   input wire logic [3:0] result_nibble_reg,
   input wire logic       carry_flag,
   input wire logic       zero_flag,
   input wire logic       ram_wr_en,
   input wire logic [6:0] ram_wr_addr,
   input wire logic [3:0] ram_wr_data,
   input wire logic       wreg_wr_en,
   input wire logic [3:0] wreg_wr_sel,
   input wire logic [3:0] wreg_wr_data,
   input wire logic       op_done,
   input wire logic       op_reject
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire logic ram_op = op_valid && !op_byte1[7];  // ram operand form request
   chk_single_answer: assert property (op_valid |=> op_done != op_reject)
      else $error("request not answered once");
   chk_idle_quiet: assert property (
      !op_valid |=> !op_done && !ram_wr_en && !wreg_wr_en)
      else $error("strobe without request");
   // operands widened by hand so the carry position is kept
   chk_ram_sum: assert property (ram_op && op_byte0 == 8'h18 |=>
      {carry_flag, result_nibble_reg} ==
      {1'b0, $past(ram_rd_data)} + {1'b0, $past(result_nibble_reg)})
      else $error("ram sum wrong");
   chk_imm_carry_sum: assert property (op_valid && op_byte0 == 8'h0c |=>
      result_nibble_reg == 4'($past(wreg_rd_data) + $past(op_byte1[7:4]) + $past(carry_flag)))
      else $error("immediate carry sum wrong");
   chk_ram_diff: assert property (ram_op && op_byte0 == 8'h1a |=>
      {carry_flag, result_nibble_reg} ==
      {1'b0, $past(ram_rd_data)} - {1'b0, $past(result_nibble_reg)})
      else $error("ram difference wrong");
   chk_ram_store: assert property (
      ram_op && op_byte0 inside {8'h09, 8'h19, 8'h0b, 8'h1b} |=>
      ram_wr_en && ram_wr_data == result_nibble_reg && ram_wr_addr == $past(op_byte1[6:0]))
      else $error("ram store wrong");
   chk_wreg_store: assert property (
      op_valid && op_byte0 inside {8'h0d, 8'h1d, 8'h0f, 8'h1f} |=>
      wreg_wr_en && wreg_wr_data == result_nibble_reg && wreg_wr_sel == $past(op_byte1[3:0]))
      else $error("register store wrong");
   chk_keep_carry: assert property (
      op_valid && op_byte0[7:4] == 4'h2 |=> $stable(carry_flag))
      else $error("carry moved on keep carry form");
   chk_zero_match: assert property (
      op_done |-> zero_flag == (result_nibble_reg == 4'h0))
      else $error("zero flag disagrees with result");
   chk_step_down: assert property (op_valid && op_byte0 == 8'h4a && op_byte1[7] |=>
      ram_wr_en && result_nibble_reg == 4'($past(ram_rd_data) - 4'h1))
      else $error("step down wrong");
   cover property (op_done && ram_wr_en);
   cover property (op_done && carry_flag);
   cover property (op_reject);
endmodule // nibble_arithmetic_unit_monitor
bind nibble_arithmetic_unit nibble_arithmetic_unit_monitor nibble_arithmetic_unit_monitor_inst (
   .clk_sys, .rst, .op_valid, .op_byte0, .op_byte1, .ram_rd_data, .wreg_rd_data,
   .result_nibble_reg, .carry_flag, .zero_flag, .ram_wr_en, .ram_wr_addr, .ram_wr_data,
   .wreg_wr_en, .wreg_wr_sel, .wreg_wr_data, .op_done, .op_reject);

// ===== tb/nibble_operand_store.sv
// data ram and working registers behind the arithmetic unit
`timescale 1ns/1ns
module nibble_operand_store (
   input  wire logic       clk_sys,
   input  wire logic [7:0] op_byte1,
   input  wire logic       ram_wr_en,
   input  wire logic [6:0] ram_wr_addr,
   input  wire logic [3:0] ram_wr_data,
   input  wire logic       wreg_wr_en,
   input  wire logic [3:0] wreg_wr_sel,
   input  wire logic [3:0] wreg_wr_data,
   output logic      [3:0] ram_rd_data,
   output logic      [3:0] wreg_rd_data
);
   logic [3:0] ram_q [128];  // data ram nibbles
   logic [3:0] wreg_q [16];  // working registers
   // known start pattern: address 4 holds f, address 11 holds 0
   initial begin
      for (int i = 0; i < 128; i++) ram_q[i] = 4'(i * 7 + 3);
      for (int i = 0; i < 16; i++) wreg_q[i] = 4'(15 - i);
   end
   // writes land at the edge that ends the strobe cycle
   always @(posedge clk_sys) begin
      if (ram_wr_en) ram_q[ram_wr_addr] <= ram_wr_data;
      if (wreg_wr_en) wreg_q[wreg_wr_sel] <= wreg_wr_data;
   end
   // forward a write still in flight so a following op sees it
   always_comb begin
      ram_rd_data = ram_q[op_byte1[6:0]];
      wreg_rd_data = wreg_q[op_byte1[3:0]];
      if (ram_wr_en && ram_wr_addr == op_byte1[6:0]) ram_rd_data = ram_wr_data;
      if (wreg_wr_en && wreg_wr_sel == op_byte1[3:0]) wreg_rd_data = wreg_wr_data;
   end
endmodule // nibble_operand_store

// ===== tb/nibble_arithmetic_unit_tb.sv
// self-checking bench for the nibble arithmetic unit
`timescale 1ns/1ns
module nibble_arithmetic_unit_tb;
   logic       clk_sys, rst = 1'b1, op_valid = 1'b0, carry_flag, zero_flag;
   logic       ram_wr_en, wreg_wr_en, op_done, op_reject;
   logic [7:0] op_byte0 = 8'h00, op_byte1 = 8'h00;
   logic [6:0] ram_wr_addr;
   logic [3:0] ram_rd_data, wreg_rd_data, result_nibble_reg, ram_wr_data, wreg_wr_sel;
   logic [3:0] wreg_wr_data, ram_s, wreg_s;  // operands seen in the request cycle
   logic [3:0] result_m = 4'h0;              // expected result register
   logic       carry_m = 1'b0, zero_m = 1'b1; // expected flags
   int         bad_count = 0, n_compared = 0;
   nibble_arithmetic_unit nibble_arithmetic_unit_inst (.clk_sys, .rst, .op_valid, .op_byte0,
      .op_byte1, .ram_rd_data, .wreg_rd_data, .result_nibble_reg, .carry_flag, .zero_flag,
      .ram_wr_en, .ram_wr_addr, .ram_wr_data, .wreg_wr_en, .wreg_wr_sel, .wreg_wr_data,
      .op_done, .op_reject);
   nibble_operand_store nibble_operand_store_inst (.clk_sys, .op_byte1, .ram_wr_en,
      .ram_wr_addr, .ram_wr_data, .wreg_wr_en, .wreg_wr_sel, .wreg_wr_data, .ram_rd_data,
      .wreg_rd_data);
   // closing verdict
   task automatic print_verdict();
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // compare one value
   // wide enough for the ram address and data compared together
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one request cycle; operands captured while it stands
   task automatic issue(input logic [7:0] b0, input logic [7:0] b1);
      @(posedge clk_sys);
      op_valid <= 1'b1;
      op_byte0 <= b0;
      op_byte1 <= b1;
      #1;
      ram_s = ram_rd_data;
      wreg_s = wreg_rd_data;
      @(posedge clk_sys);
      op_valid <= 1'b0;
      #1;
   endtask
   // reference result as {carry, nibble}
   function automatic logic [4:0] ref_op(input logic [7:0] b0, input logic [7:0] b1);
      logic [4:0] a, b, r;
      logic cin, sub;
      a = {1'b0, b0[2] ? wreg_s : ram_s};
      b = (b0 == 8'h4a) ? 5'h01 : {1'b0, b0[2] ? b1[7:4] : result_m};
      cin = (b0[7:4] == 4'h0) ? carry_m : 1'b0;
      sub = (b0 == 8'h4a) ? b1[7] : b0[1];
      r = sub ? a - b - 5'(cin) : a + b + 5'(cin);
      if (b0[7:4] == 4'h2) r[4] = carry_m;
      return r;
   endfunction
   // issue, then judge result, flags, pulses and strobes; write address and data only when a store is expected
   task automatic run_op(input logic [7:0] b0, input logic [7:0] b1, input logic take);
      logic [4:0] r;
      logic       z, st_r, st_w;
      issue(b0, b1);
      r = take ? ref_op(b0, b1) : {carry_m, result_m};
      z = take ? (r[3:0] == 4'h0) : zero_m;
      st_r = take && (b0 == 8'h4a || (b0[0] && !b0[2]));
      st_w = take && b0[0] && b0[2];
      check(result_nibble_reg, r[3:0]);
      check(carry_flag, r[4]);
      check(zero_flag, z);
      check({op_done, op_reject}, {take, !take});
      check({ram_wr_en, wreg_wr_en}, {st_r, st_w});
      if (st_r) check({ram_wr_addr, ram_wr_data}, {b1[6:0], r[3:0]});
      if (st_w) check({wreg_wr_sel, wreg_wr_data}, {b1[3:0], r[3:0]});
      result_m = r[3:0];
      carry_m = r[4];
      zero_m = z;
   endtask
   // values after reset
   task automatic test_reset();
      check({result_nibble_reg, carry_flag, zero_flag}, {4'h0, 1'b0, 1'b1});
   endtask
   // step up from f and down from 0 wrap with carry
   task automatic test_steps();
      run_op(8'h4a, 8'h04, 1'b1);
      run_op(8'h4a, 8'h8b, 1'b1);
      run_op(8'h4a, 8'h84, 1'b1);
   endtask
   // all eight forms of one group
   task automatic test_group(input logic [3:0] g);
      for (int lo = 8; lo < 16; lo++)
         run_op({g, 4'(lo)}, lo[2] ? {4'(lo * 3), 4'(lo)} : {1'b0, 7'(lo * 5)}, 1'b1);
   endtask
   // borrow set first, then keep-carry sums must leave it
   task automatic test_keep_carry();
      run_op(8'h1e, 8'hfe, 1'b1);
      run_op(8'h28, 8'h36, 1'b1);
      run_op(8'h29, 8'h36, 1'b1);
      run_op(8'h2c, 8'h36, 1'b1);
      run_op(8'h2d, 8'h36, 1'b1);
   endtask
   // foreign codes and a malformed ram form change nothing
   task automatic test_reject();
      run_op(8'h2a, 8'h01, 1'b0);
      run_op(8'h18, 8'h81, 1'b0);
      run_op(8'h55, 8'h00, 1'b0);
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // hang guard, far above the 56 cycles needed
   initial begin
      repeat (3000) @(posedge clk_sys);
      bad_count++;
      print_verdict();
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      test_reset();
      test_steps();
      test_group(4'h1);
      test_group(4'h0);
      test_keep_carry();
      test_reject();
      print_verdict();
   end
endmodule // nibble_arithmetic_unit_tb
